// *** logic/vxg_defs.svh ***
// constants for the virtual exception gate
`ifndef VXG_DEFS_SVH
`define VXG_DEFS_SVH

`define VXG_NCLASS 3
`define VXG_IDX_ABORT 0
`define VXG_IDX_IRQ 1
`define VXG_IDX_FIQ 2

`define VXG_RST_VEC 3'h0
`define VXG_RST_REQ 1'h0

`endif

// *** logic/vxg_pkg.sv ***
// types for the virtual exception gate
package vxg_pkg;

   // one bit per class, abort in bit 0, irq in bit 1, fiq in bit 2
   typedef struct packed {
      logic fiq;
      logic irq;
      logic abort;
   } vxg_trio_s;

   typedef struct packed {
      logic fiq_to_monitor;
      logic irq_to_monitor;
      logic ext_abort_to_monitor;
   } vxg_route_s;

   typedef struct packed {
      logic virt_fiq_override;
      logic virt_irq_override;
      logic virt_abort_override;
   } vxg_override_s;

   typedef enum logic [4:0] {
      VXG_MODE_NONE    = 5'h01,
      VXG_MODE_ABORT   = 5'h02,
      VXG_MODE_IRQ     = 5'h04,
      VXG_MODE_FIQ     = 5'h08,
      VXG_MODE_MONITOR = 5'h10
   } vxg_mode_e;

   typedef enum logic [2:0] {
      VXG_ST_IDLE  = 3'h1,
      VXG_ST_REQ   = 3'h2,
      VXG_ST_DRAIN = 3'h4
   } vxg_state_e;

   typedef struct packed {
      vxg_state_e state;
      vxg_trio_s take;
      vxg_trio_s to_mon;
      vxg_trio_s held;
      logic req;
      vxg_trio_s cls;
      vxg_mode_e mode;
   } vxg_regs_s;

endpackage

// *** logic/vxg_class_gate.sv ***
// take decision for one asynchronous exception class
`timescale 1ns/1ns
module vxg_class_gate (
   input wire logic pending,
   input wire logic secure_state,
   input wire logic route_bit,
   input wire logic mask_bit,
   input wire logic override_bit,
   output logic take,
   output logic to_monitor,
   output logic held
);
   logic eff_mask;

   always_comb begin
      to_monitor = !secure_state && route_bit;
      if (secure_state) begin
         eff_mask = mask_bit;
      end else if (!route_bit) begin
         eff_mask = mask_bit;
      end else begin
         // override lifts the mask so the monitor path still sees it
         eff_mask = mask_bit && !override_bit;
      end
      take = pending && !eff_mask;
      held = pending && eff_mask;
   end
endmodule

// *** logic/vxg_gate.sv ***
// virtual exception gate: decides and presents asynchronous exception entry
// Operation
// - in secure state the three virtualization override bits have no effect
// - in secure state only the matching status mask bit gates each exception
// - non-secure with routing bit clear: only the matching mask bit gates it
// - non-secure with routing bit set: exception goes to monitor mode
// - monitor-routed exceptions use the mask bit qualified by its override bit
`timescale 1ns/1ns
`include "vxg_defs.svh"
module vxg_gate
   import vxg_pkg::*;
#(
   parameter int NCLASS = `VXG_NCLASS
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire vxg_trio_s pending,
   input wire logic secure_state,
   input wire vxg_route_s secure_config_reg,
   input wire vxg_trio_s program_status_mask,
   input wire vxg_override_s virt_override,
   input wire logic entry_ack,
   output vxg_trio_s take_now,
   output vxg_trio_s route_monitor,
   output vxg_trio_s held_off,
   output logic entry_req,
   output vxg_trio_s entry_class,
   output vxg_mode_e entry_mode
);

   vxg_regs_s r_reg;
   vxg_regs_s r_next;

   logic [NCLASS-1:0] pend_v;
   logic [NCLASS-1:0] route_v;
   logic [NCLASS-1:0] mask_v;
   logic [NCLASS-1:0] ovr_v;
   logic [NCLASS-1:0] take_v;
   logic [NCLASS-1:0] mon_v;
   logic [NCLASS-1:0] held_v;

   function automatic logic [2:0] route_vec(input vxg_route_s r);
      logic [2:0] v;
      v = `VXG_RST_VEC;
      v[`VXG_IDX_ABORT] = r.ext_abort_to_monitor;
      v[`VXG_IDX_IRQ] = r.irq_to_monitor;
      v[`VXG_IDX_FIQ] = r.fiq_to_monitor;
      return v;
   endfunction

   function automatic logic [2:0] ovr_vec(input vxg_override_s o);
      logic [2:0] v;
      v = `VXG_RST_VEC;
      v[`VXG_IDX_ABORT] = o.virt_abort_override;
      v[`VXG_IDX_IRQ] = o.virt_irq_override;
      v[`VXG_IDX_FIQ] = o.virt_fiq_override;
      return v;
   endfunction

   function automatic vxg_trio_s to_trio(input logic [2:0] v);
      vxg_trio_s t;
      t.abort = v[`VXG_IDX_ABORT];
      t.irq = v[`VXG_IDX_IRQ];
      t.fiq = v[`VXG_IDX_FIQ];
      return t;
   endfunction

   function automatic logic [2:0] from_trio(input vxg_trio_s t);
      logic [2:0] v;
      v = `VXG_RST_VEC;
      v[`VXG_IDX_ABORT] = t.abort;
      v[`VXG_IDX_IRQ] = t.irq;
      v[`VXG_IDX_FIQ] = t.fiq;
      return v;
   endfunction

   // abort first, then fiq, then irq
   function automatic logic [2:0] pick(input logic [2:0] v);
      logic [2:0] p;
      p = `VXG_RST_VEC;
      if (v[`VXG_IDX_ABORT]) begin
         p[`VXG_IDX_ABORT] = 1'b1;
      end else if (v[`VXG_IDX_FIQ]) begin
         p[`VXG_IDX_FIQ] = 1'b1;
      end else if (v[`VXG_IDX_IRQ]) begin
         p[`VXG_IDX_IRQ] = 1'b1;
      end
      return p;
   endfunction

   function automatic vxg_mode_e mode_of(input logic [2:0] sel, input logic [2:0] mon);
      vxg_mode_e m;
      m = VXG_MODE_NONE;
      if ((sel & mon) != `VXG_RST_VEC) begin
         m = VXG_MODE_MONITOR;
      end else if (sel[`VXG_IDX_ABORT]) begin
         m = VXG_MODE_ABORT;
      end else if (sel[`VXG_IDX_FIQ]) begin
         m = VXG_MODE_FIQ;
      end else if (sel[`VXG_IDX_IRQ]) begin
         m = VXG_MODE_IRQ;
      end
      return m;
   endfunction

   // request fields back to idle; status fields are left as computed
   function automatic vxg_regs_s drop_req(input vxg_regs_s r, input vxg_state_e st);
      vxg_regs_s d;
      d = r;
      d.state = st;
      d.req = `VXG_RST_REQ;
      d.cls = to_trio(`VXG_RST_VEC);
      d.mode = VXG_MODE_NONE;
      return d;
   endfunction

   // reset image, also the way out of an illegal state code
   function automatic vxg_regs_s regs_reset();
      vxg_regs_s z;
      z.state = VXG_ST_IDLE;
      z.take = to_trio(`VXG_RST_VEC);
      z.to_mon = to_trio(`VXG_RST_VEC);
      z.held = to_trio(`VXG_RST_VEC);
      z.req = `VXG_RST_REQ;
      z.cls = to_trio(`VXG_RST_VEC);
      z.mode = VXG_MODE_NONE;
      return z;
   endfunction

   // flat vectors let the generate loop index each class by number
   always_comb begin
      pend_v = from_trio(pending);
      mask_v = from_trio(program_status_mask);
      route_v = route_vec(secure_config_reg);
      ovr_v = ovr_vec(virt_override);
   end

   // each class sees only its own routing, mask and override bit
   genvar gi;
   generate
      for (gi = 0; gi < NCLASS; gi = gi + 1) begin : g_class
         vxg_class_gate u_gate (
            .pending(pend_v[gi]),
            .secure_state(secure_state),
            .route_bit(route_v[gi]),
            .mask_bit(mask_v[gi]),
            .override_bit(ovr_v[gi]),
            .take(take_v[gi]),
            .to_monitor(mon_v[gi]),
            .held(held_v[gi])
         );
      end
   endgenerate

   always_comb begin
      logic [2:0] sel;
      logic [2:0] cur;
      sel = pick(take_v);
      cur = from_trio(r_reg.cls);
      r_next = r_reg;
      // status follows the class gates in every state
      r_next.take = to_trio(take_v);
      r_next.to_mon = to_trio(mon_v);
      r_next.held = to_trio(held_v);
      unique case (r_reg.state)
         VXG_ST_IDLE: begin
            // highest taken class starts a request
            if (sel != `VXG_RST_VEC) begin
               r_next.state = VXG_ST_REQ;
               r_next.req = 1'b1;
               r_next.cls = to_trio(sel);
               r_next.mode = mode_of(sel, mon_v);
            end
         end
         VXG_ST_REQ: begin
            if (entry_ack) begin
               // one quiet cycle lets the source drop its line before re-sampling
               r_next = drop_req(r_next, VXG_ST_DRAIN);
            end else if ((take_v & cur) == `VXG_RST_VEC) begin
               // level sources may withdraw or be masked before entry
               r_next = drop_req(r_next, VXG_ST_IDLE);
            end else if (sel != cur) begin
               // a higher class overtakes a request not yet accepted
               r_next.cls = to_trio(sel);
               r_next.mode = mode_of(sel, mon_v);
            end else begin
               r_next.mode = mode_of(cur, mon_v);
            end
         end
         VXG_ST_DRAIN: begin
            r_next.state = VXG_ST_IDLE;
         end
         // one-hot codes leave illegal values; restart idle, status kept live
         default: begin
            r_next = regs_reset();
            r_next.take = to_trio(take_v);
            r_next.to_mon = to_trio(mon_v);
            r_next.held = to_trio(held_v);
         end
      endcase
   end

   // synchronous reset, sampled like any other input
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         r_reg <= regs_reset();
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs come straight from the state register
   assign take_now = r_reg.take;
   assign route_monitor = r_reg.to_mon;
   assign held_off = r_reg.held;
   assign entry_req = r_reg.req;
   assign entry_class = r_reg.cls;
   assign entry_mode = r_reg.mode;

endmodule

// *** verif/vxg_gate_assertions.sv ***
// concurrent checks on the gate ports
`timescale 1ns/1ns
module vxg_gate_assertions
   import vxg_pkg::*;
#(
   parameter int NCLASS = 3
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire vxg_trio_s pending,
   input wire logic secure_state,
   input wire vxg_route_s secure_config_reg,
   input wire vxg_trio_s program_status_mask,
   input wire vxg_override_s virt_override,
   input wire logic entry_ack,
   input wire vxg_trio_s take_now,
   input wire vxg_trio_s route_monitor,
   input wire vxg_trio_s held_off,
   input wire logic entry_req,
   input wire vxg_trio_s entry_class,
   input wire vxg_mode_e entry_mode
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   logic [2:0] em;
   logic [2:0] tk;
   logic [2:0] sk;
   // override lifts a mask only for monitor-routed non-secure classes
   assign em = program_status_mask & ~(virt_override & secure_config_reg & {3{~secure_state}});
   assign tk = pending & ~em;
   assign sk = pending & ~program_status_mask;
   a_secure_take: assert property (!$past(srst) && $past(secure_state) |-> take_now == $past(sk))
      else $error("secure take wrong");
   a_take_now: assert property (!$past(srst) |-> take_now == $past(tk))
      else $error("take wrong");
   a_held_off: assert property (!$past(srst) |-> held_off == $past(pending & em))
      else $error("held wrong");
   a_route_mon: assert property (!$past(srst) |-> route_monitor == $past(secure_config_reg & {3{~secure_state}}))
      else $error("route wrong");
   a_req_cause: assert property ($rose(entry_req) |-> (|(entry_class & take_now)) && $onehot(entry_class))
      else $error("request without cause");
   a_mon_mode: assert property (entry_req && |(entry_class & route_monitor) |-> entry_mode == VXG_MODE_MONITOR)
      else $error("monitor mode wrong");
endmodule

bind vxg_gate vxg_gate_assertions #(.NCLASS(NCLASS)) i_vxg_gate_assertions (.*);

// *** verif/vxg_irq_source.sv ***
// interrupt controller model holding request levels
`timescale 1ns/1ns
module vxg_irq_source
   import vxg_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [2:0] raise,
   input wire logic [2:0] drop,
   output vxg_trio_s pending
);
   // level stays until dropped, like a real controller line
   always_ff @(posedge ref_clk) begin
      pending <= srst ? 3'h0 : (pending | raise) & ~drop;
   end
endmodule

// *** verif/tb_vxg_gate.sv ***
// testbench for the virtual exception gate
`timescale 1ns/1ns
module tb_vxg_gate
   import vxg_pkg::*;
;
   logic ref_clk = 1'h0, srst = 1'h1, sec = 1'h1, ack = 1'h0;
   logic [2:0] rt = 3'h0, msk = 3'h0, ov = 3'h0, pend = 3'h0, em;
   vxg_trio_s pending, take_now, route_monitor, held_off, entry_class;
   logic entry_req;
   vxg_mode_e entry_mode;
   int n_errors = 0, samples_checked = 0;
   // sec, route, mask, override, pending, class, mode
   logic [20:0] hs [4] = '{21'h100244, 21'h049250, 21'h100322, 21'h100688};
   always #50 ref_clk = ~ref_clk;
   vxg_irq_source i_vxg_irq_source (.ref_clk(ref_clk), .srst(srst), .raise(pend), .drop(~pend),
      .pending(pending));
   vxg_gate i_vxg_gate (.ref_clk(ref_clk), .srst(srst), .pending(pending), .secure_state(sec),
      .secure_config_reg(rt), .program_status_mask(msk), .virt_override(ov), .entry_ack(ack),
      .take_now(take_now), .route_monitor(route_monitor), .held_off(held_off),
      .entry_req(entry_req), .entry_class(entry_class), .entry_mode(entry_mode));
   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      step(2);
      srst = 1'h0;
      // every input combination; two edges for the source then the gate
      for (int i = 0; i < 8192; i++) begin
         {sec, rt, msk, ov, pend} = i[12:0];
         step(2);
         em = msk & ~(ov & rt & {3{~sec}});
         check("take_now", take_now, pend & ~em);
         check("held_off", held_off, pend & em);
         check("route_monitor", route_monitor, rt & {3{~sec}});
      end
      $display("test truth table done");
      // irq request overtaken by fiq, withdrawn by mask, then drain after ack
      pend = 3'h0;
      step(4);
      {sec, rt, msk, ov, pend} = 13'h1002;
      step(2);
      check("entry_class", entry_class, 3'h2);
      pend = 3'h6;
      step(2);
      check("entry_req", entry_req, 1'h1);
      check("entry_class", entry_class, 3'h4);
      check("entry_mode", entry_mode, VXG_MODE_FIQ);
      msk = 3'h6;
      step(1);
      check("entry_req", entry_req, 1'h0);
      msk = 3'h0;
      step(1);
      check("entry_req", entry_req, 1'h1);
      ack = 1'h1;
      step(1);
      ack = 1'h0;
      step(1);
      check("entry_req", entry_req, 1'h0);
      step(1);
      check("entry_req", entry_req, 1'h1);
      $display("test overtake withdraw drain done");
      for (int k = 0; k < 4; k++) begin
         pend = 3'h0;
         step(4);
         {sec, rt, msk, ov, pend} = hs[k][20:8];
         step(2);
         check("entry_req", entry_req, 1'h1);
         check("entry_class", entry_class, hs[k][7:5]);
         check("entry_mode", entry_mode, hs[k][4:0]);
         ack = 1'h1;
         step(1);
         ack = 1'h0;
         check("entry_req", entry_req, 1'h0);
         check("entry_mode", entry_mode, VXG_MODE_NONE);
      end
      $display("test entry handshake done");
      summarize;
   end
   initial begin
      step(30000);
      n_errors++;
      summarize;
   end
endmodule
